// [iowd_regs.svh]
/*
 Register offset, jumper encodings and timing counts for the I/O-write watchdog.
 Assumes a 200 MHz board clock and a 16-bit host I/O address space.
*/
`ifndef IOWD_REGS_SVH
`define IOWD_REGS_SVH

`define IOWD_KICK_PORT_ADDR   16'h0093
`define IOWD_CLK_HZ           200000000
`define IOWD_SHORT_TIMEOUT_S  2
`define IOWD_LONG_TIMEOUT_S   8
`define IOWD_SHORT_CYCLES     (`IOWD_SHORT_TIMEOUT_S * `IOWD_CLK_HZ)
`define IOWD_LONG_CYCLES      (`IOWD_LONG_TIMEOUT_S * `IOWD_CLK_HZ)
`define IOWD_TICK_HZ          1000
`define IOWD_RESET_PULSE_CYC  16

`endif

// [iowd_pkg.sv]
/*
 Types for the I/O-write watchdog.
 Assumes iowd_regs.svh supplies the numeric constants.
*/
package iowd_pkg;

	typedef enum logic [2:0] {
		IOWD_IDLE  = 3'b001,
		IOWD_ARMED = 3'b010,
		IOWD_FIRE  = 3'b100
	} iowd_state_t;

	typedef struct packed {
		iowd_state_t state;
		logic [31:0] pre;
		logic [31:0] ticks;
		logic [31:0] pulse;
		logic        rst_out;
	} iowd_regs_t;

endpackage

// [iowd_watchdog.sv]
/*
 I/O-write watchdog: armed and kicked by host writes to the kick port,
 fires a board reset pulse when a full timeout passes without a kick.
 Assumes host I/O strobes are synchronous to clk_in and one cycle long,
 and that the reset pulse it drives comes back on reset_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iowd_regs.svh"

// Behaviour
// - Jumper selects a 2 second or 8 second timeout.
// - Board reset leaves the watchdog disabled and not counting.
// - Any write to port 93H arms it, data ignored.
// - Host must rewrite before timeout, otherwise board reset is asserted.
// - Once armed, no software access can stop it; only reset or removing the enable link.
// - Enable link removed keeps watchdog inactive; a reset pulse already started still runs to its end.
module iowd_watchdog #(
	parameter int unsigned CLK_HZ       = `IOWD_CLK_HZ,
	parameter int unsigned TICK_HZ      = `IOWD_TICK_HZ,
	parameter int unsigned SHORT_SEC    = `IOWD_SHORT_TIMEOUT_S,
	parameter int unsigned LONG_SEC     = `IOWD_LONG_TIMEOUT_S,
	parameter int unsigned PULSE_CYCLES = `IOWD_RESET_PULSE_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic [7:0]  io_wdata_in,
	input  wire logic        io_write_in,
	input  wire logic        timeout_select_link_in,
	input  wire logic        watchdog_enable_link_in,
	output logic             board_reset_out,
	output logic             armed_out
);

	// Counters are 32 bits so long timeouts at fast clocks still fit
	localparam int unsigned PRESCALE    = CLK_HZ / TICK_HZ;
	localparam logic [31:0] SHORT_TICKS = 32'(SHORT_SEC * TICK_HZ);
	localparam logic [31:0] LONG_TICKS  = 32'(LONG_SEC * TICK_HZ);
	localparam logic [31:0] PRE_LAST    = 32'(PRESCALE - 1);
	localparam logic [31:0] PULSE_LAST  = 32'(PULSE_CYCLES - 1);

	function automatic logic is_kick(
		input logic [15:0] addr,
		input logic        write
	);
		// Data bus is never looked at, any value kicks
		is_kick = write && (addr == `IOWD_KICK_PORT_ADDR);
	endfunction

	function automatic logic [31:0] pick_limit(
		input logic sel
	);
		pick_limit = sel ? LONG_TICKS : SHORT_TICKS;
	endfunction

	// Every counter is cleared before it can wrap
	function automatic logic [31:0] bump(
		input logic [31:0] value
	);
		bump = value + 32'd1;
	endfunction

	function automatic logic at_last(
		input logic [31:0] value,
		input logic [31:0] last
	);
		at_last = (value == last);
	endfunction

	function automatic iowd_pkg::iowd_regs_t restart(
		input iowd_pkg::iowd_regs_t regs
	);
		iowd_pkg::iowd_regs_t fresh;
		fresh       = regs;
		fresh.pre   = '0;
		fresh.ticks = '0;
		restart     = fresh;
	endfunction

	function automatic iowd_pkg::iowd_regs_t fire_entry(
		input iowd_pkg::iowd_regs_t regs
	);
		iowd_pkg::iowd_regs_t nxt;
		nxt         = regs;
		nxt.pre     = '0;
		nxt.pulse   = '0;
		nxt.rst_out = 1'b1;
		nxt.state   = iowd_pkg::IOWD_FIRE;
		fire_entry  = nxt;
	endfunction

	function automatic iowd_pkg::iowd_regs_t step_idle(
		input iowd_pkg::iowd_regs_t regs,
		input logic                 kick_now,
		input logic                 link_now
	);
		iowd_pkg::iowd_regs_t nxt;
		nxt         = regs;
		nxt.rst_out = 1'b0;
		if (kick_now && link_now) begin
			nxt       = restart(nxt);
			nxt.state = iowd_pkg::IOWD_ARMED;
		end
		step_idle = nxt;
	endfunction

	function automatic iowd_pkg::iowd_regs_t step_armed(
		input iowd_pkg::iowd_regs_t regs,
		input logic                 kick_now,
		input logic                 link_now,
		input logic                 tick_now,
		input logic                 timeout_now
	);
		iowd_pkg::iowd_regs_t nxt;
		nxt         = regs;
		nxt.rst_out = 1'b0;
		// Besides a timeout or reset_in, only the link, a hardware strap, can take the timer out of this state
		if (!link_now) begin
			nxt.state = iowd_pkg::IOWD_IDLE;
		end else if (kick_now) begin
			nxt = restart(nxt);
		end else if (timeout_now) begin
			nxt = fire_entry(nxt);
		end else if (tick_now) begin
			nxt.pre   = '0;
			nxt.ticks = bump(regs.ticks);
		end else begin
			nxt.pre = bump(regs.pre);
		end
		step_armed = nxt;
	endfunction

	function automatic iowd_pkg::iowd_regs_t step_fire(
		input iowd_pkg::iowd_regs_t regs,
		input logic                 done_now
	);
		iowd_pkg::iowd_regs_t nxt;
		nxt = regs;
		// Kicks are not looked at, so a late write cannot shorten the pulse
		if (done_now) begin
			nxt.rst_out = 1'b0;
			nxt.state   = iowd_pkg::IOWD_IDLE;
		end else begin
			nxt.rst_out = 1'b1;
			nxt.pulse   = bump(regs.pulse);
		end
		step_fire = nxt;
	endfunction

	iowd_pkg::iowd_regs_t state_reg;
	iowd_pkg::iowd_regs_t state_next;

	// Decoded strobes shared by the state steps
	logic                 kick;
	logic [31:0]          limit;
	logic                 link_fitted;
	logic                 tick_due;
	logic                 timeout_due;
	logic                 pulse_done;

	assign kick        = is_kick(io_addr_in, io_write_in);
	assign limit       = pick_limit(timeout_select_link_in);
	assign link_fitted = watchdog_enable_link_in;

	assign tick_due    = at_last(state_reg.pre, PRE_LAST);
	// Select is read live, so moving the jumper while armed takes effect at once
	assign timeout_due = tick_due && (bump(state_reg.ticks) >= limit);
	assign pulse_done  = at_last(state_reg.pulse, PULSE_LAST);

	// Next state; each state has its own step function
	always_comb begin
		state_next         = state_reg;
		state_next.rst_out = 1'b0;
		unique case (state_reg.state)
			iowd_pkg::IOWD_IDLE: begin
				state_next = step_idle(state_reg, kick, link_fitted);
			end
			iowd_pkg::IOWD_ARMED: begin
				state_next = step_armed(state_reg, kick, link_fitted, tick_due, timeout_due);
			end
			iowd_pkg::IOWD_FIRE: begin
				state_next = step_fire(state_reg, pulse_done);
			end
			// Illegal one-hot codes fall back to the safe disabled state
			default: begin
				state_next.state = iowd_pkg::IOWD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_reg.state   <= iowd_pkg::IOWD_IDLE;
			state_reg.pre     <= '0;
			state_reg.ticks   <= '0;
			state_reg.pulse   <= '0;
			state_reg.rst_out <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Reset output comes straight from a flip-flop, so it cannot glitch
	assign board_reset_out = state_reg.rst_out;
	assign armed_out       = (state_reg.state == iowd_pkg::IOWD_ARMED);

endmodule

`default_nettype wire

// [iowd_checker.sv]
/* Port checker for iowd_watchdog.
 Assumes one clock; bound into the design below. */
`timescale 1ns/1ps
`default_nettype none
module iowd_checker #(parameter int unsigned CLK_HZ = 100, SHORT_SEC = 2, LONG_SEC = 8) (
	input	wire logic		clk_in,
	input	wire logic		reset_in,
	input	wire logic [15:0]	io_addr_in,
	input	wire logic		io_write_in,
	input	wire logic		timeout_select_link_in,
	input	wire logic		watchdog_enable_link_in,
	input	wire logic		board_reset_out,
	input	wire logic		armed_out
);
	logic	[31:0]	gap_reg;
	wire	logic	kick = io_write_in && io_addr_in == 16'h0093 && watchdog_enable_link_in;
	// Cycles since the last kick, to time the fire edge
	always_ff @(posedge clk_in) gap_reg <= kick ? 32'h0 : gap_reg + 32'h1;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_kick_arms: assert property (kick && !board_reset_out |=> armed_out)
		else $error("kick did not arm");
	a_reset_clears: assert property ($fell(reset_in) |-> !armed_out && !board_reset_out)
		else $error("active after reset");
	a_link_inert: assert property (!watchdog_enable_link_in |=> !armed_out)
		else $error("armed without link");
	a_no_sw_stop: assert property (armed_out && watchdog_enable_link_in |=> armed_out || board_reset_out)
		else $error("armed state lost");
	a_fire_on_drop: assert property ($fell(armed_out) && $past(watchdog_enable_link_in) |-> board_reset_out)
		else $error("no reset at timeout");
	a_fire_time: assert property ($rose(board_reset_out) |-> gap_reg == (timeout_select_link_in ? LONG_SEC : SHORT_SEC) * CLK_HZ)
		else $error("wrong timeout length");
	a_pulse_hold: assert property ($rose(board_reset_out) |-> board_reset_out[*8])
		else $error("reset pulse short");
	c_short: cover property ($rose(board_reset_out) && !timeout_select_link_in);
	c_long: cover property ($rose(board_reset_out) && timeout_select_link_in);
	c_inert: cover property (io_write_in && !watchdog_enable_link_in);
endmodule
bind iowd_watchdog iowd_checker #(.CLK_HZ(CLK_HZ), .SHORT_SEC(SHORT_SEC), .LONG_SEC(LONG_SEC)) chk (
	.clk_in(clk_in), .reset_in(reset_in), .io_addr_in(io_addr_in), .io_write_in(io_write_in),
	.timeout_select_link_in(timeout_select_link_in), .watchdog_enable_link_in(watchdog_enable_link_in),
	.board_reset_out(board_reset_out), .armed_out(armed_out));
`default_nettype wire

// [iowd_host.sv]
/* Host model issuing one-cycle I/O writes.
 Assumes the bench calls write_io from its main sequence. */
`timescale 1ns/1ps
`default_nettype none
module iowd_host (
	input	wire logic		clk_in,
	output	logic [15:0]	addr_out,
	output	logic [7:0]	data_out,
	output	logic		write_out
);
	initial {addr_out, data_out, write_out} = 25'h0;
	// write cycle, any data; released bus shows inverted lines
	task automatic write_io(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_in) {addr_out, data_out, write_out} = {a, d, 1'b1};
		@(negedge clk_in) {addr_out, data_out, write_out} = {~a, ~d, 1'b0};
	endtask
endmodule
`default_nettype wire

// [test_io_write_watchdog_timer.sv]
/* Bench for the I/O-write watchdog, shortened to 200/800 cycle timeouts.
 Assumes iowd_host and iowd_checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_io_write_watchdog_timer;
	logic	clk_in = 1'b0, reset_in = 1'b1, sel = 1'b0, link = 1'b1, w, brst, armed;
	logic	[15:0] a;
	logic	[7:0] d;
	int	failures = 0, cmp_count = 0, seed = 33575, n;
	always #2.5 clk_in = ~clk_in;
	iowd_host host (.clk_in(clk_in), .addr_out(a), .data_out(d), .write_out(w));
	iowd_watchdog #(.CLK_HZ(100), .TICK_HZ(10)) dut (.clk_in(clk_in), .reset_in(reset_in),
		.io_addr_in(a), .io_wdata_in(d), .io_write_in(w), .timeout_select_link_in(sel),
		.watchdog_enable_link_in(link), .board_reset_out(brst), .armed_out(armed));
	function automatic int want(input logic s); return s ? 800 : 200; endfunction
	task automatic chk(input string s, input logic [15:0] e, g);
		cmp_count++;
		if (e !== g) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic rst;
		@(negedge clk_in) reset_in = 1'b1;
		repeat (16) @(negedge clk_in);
		reset_in = 1'b0;
		chk("armed", 16'h0, 16'(armed));
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Run is under 5000 cycles, so this only trips on a hang
	initial begin
		#100000;
		failures++;
		tally_and_finish();
	end
	initial begin
		rst();
		host.write_io(16'($random(seed)) | 16'h0100, 8'h00);
		chk("stray", 16'h0, 16'(armed));
		for (int t = 0; t < 2; t++) begin
			sel = t[0];
			host.write_io(16'h0093, 8'($random(seed)));
			repeat ({$random(seed)} % 150) @(negedge clk_in);
			host.write_io(16'h0093, 8'($random(seed)));
			chk("armed", 16'h1, 16'(armed));
			host.write_io(16'h0092, 8'h00);
			chk("kept", 16'h1, 16'(armed));
			for (n = 2; brst !== 1'b1 && n < 900; n++) @(posedge clk_in) #1;
			chk("timeout", 16'(want(sel)), 16'(n));
			chk("fired", 16'h0, 16'(armed));
			$display("timeout test %0d done", t);
			rst();
		end
		host.write_io(16'h0093, 8'hff);
		rst();
		link = 1'b0;
		host.write_io(16'h0093, 8'h00);
		n = 0;
		repeat (250) @(negedge clk_in) n += int'(brst !== 1'b0 || armed !== 1'b0);
		chk("inert", 16'h0, 16'(n));
		$display("inert test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
